// >>> rtl/mtm_pkg.sv
/*
 * Shared constants and types for the eight-bit modulo timer: the register map
 * on the AHB-Lite bus, field positions, reset values, clock-source codes and
 * the packed structs that carry configuration and bus requests.
 * Assumes a 32-bit AHB-Lite bus with one word per register.
 */
package mtm_pkg;

    // ========================================================================
    // Register map (byte addresses within the block).
    // ========================================================================
    localparam logic [3:0] OFS_STATUS = 4'h0;   // Status and control.
    localparam logic [3:0] OFS_CLOCK  = 4'h4;   // Clock configuration.
    localparam logic [3:0] OFS_COUNT  = 4'h8;   // Current count, read only.
    localparam logic [3:0] OFS_WRAP   = 4'hC;   // Wrap limit.

    // ========================================================================
    // Field positions.
    // ========================================================================
    localparam int SC_FLAG_BIT  = 7;            // Overflow flag.
    localparam int SC_IRQEN_BIT = 6;            // Overflow interrupt enable.
    localparam int SC_CLEAR_BIT = 5;            // Write-only counter clear strobe.
    localparam int SC_HALT_BIT  = 4;            // Counter halt.
    localparam int CK_SRC_HI    = 5;            // Source select, upper bit.
    localparam int CK_SRC_LO    = 4;            // Source select, lower bit.
    localparam int CK_PS_HI     = 3;            // Prescale select, upper bit.
    localparam int CK_PS_LO     = 0;            // Prescale select, lower bit.

    // ========================================================================
    // Reset values and limits.
    // ========================================================================
    localparam logic       RST_HALT   = 1'b1;   // Timer starts halted.
    localparam logic       RST_IRQEN  = 1'b0;
    localparam logic [7:0] RST_COUNT  = 8'h00;
    localparam logic [7:0] RST_WRAP   = 8'h00;
    localparam logic [3:0] RST_PS     = 4'h0;
    localparam logic [3:0] PS_MAX     = 4'h8;   // Divide by 256 and above.
    localparam logic [7:0] FREE_LIMIT = 8'hFF;  // Limit used when wrap is zero.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Clock source codes.
    typedef enum logic [1:0] {
        MTM_SRC_BUS      = 2'b00,
        MTM_SRC_FIXED    = 2'b01,
        MTM_SRC_EXT_FALL = 2'b10,
        MTM_SRC_EXT_RISE = 2'b11
    } mtm_src_t;

    // Software-visible configuration.
    typedef struct packed {
        logic       irq_en;
        logic       halt;
        mtm_src_t   src;
        logic [3:0] ps;
        logic [7:0] wrap;
    } mtm_cfg_t;

    // Latched address phase of an AHB transfer.
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [3:0] addr;
    } mtm_bus_req_t;

endpackage

// >>> rtl/mtm_timer.sv
/*
 * Eight-bit modulo timer with four clock sources, a nine-step power-of-two
 * prescaler, an overflow flag and an interrupt output, behind an AHB-Lite
 * slave. Assumes one 200 MHz clock, pins sampled through two flip-flops, and
 * power-mode and debug levels that come from logic on the same clock.
 */
// The address map and the AHB-Lite register port were left to the implementer.
// How it works
// RULE_01: Eight-bit up-counter, free-running or wrapping at limit.
// RULE_02: Overflow raises interrupt when software enables it.
// RULE_03: Four sources: bus, fixed clock, pin rise, fall.
// RULE_04: Upper two source codes pick the pin clock.
// RULE_05: Prescaler divides by two's powers, 1 to 256.
// RULE_06: Counting and interrupt continue through wait mode.
// RULE_07: Stop mode disables counting and never wakes.
// RULE_08: Deep stop wake or stop reset restores defaults.
// RULE_09: Stop left by interrupt keeps all state.
// RULE_10: Debug mode suspends counting, resumes from held value.
// RULE_11: Pin clock is synchronised before its edges count.
// RULE_12: Pin clock must stay below quarter bus rate.
// RULE_13: Status: flag, enable, clear strobe, halt; rest zero.
// RULE_14: Clock config: zeros, source field, prescale field.
// RULE_15: Count register is read only, shows the count.
// RULE_16: Wrap limit register is read/write eight bits.
// RULE_17: Flag sets on wrap; read-write0, strobe, limit clear.
// RULE_18: Strobe zeroes count; halt freezes, set by reset.
// RULE_19: Codes map bus, fixed, fall, rise; count kept.
// RULE_20: Prescale codes above eight divide by 256.
`timescale 1ns/1ps

module mtm_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        fixed_freq_clock,
    input  wire logic        ext_count_clock_in,
    input  wire logic        stop_mode,
    input  wire logic        stop_exit_reset,
    input  wire logic        debug_active,
    output logic             overflow_irq
);

    // ========================================================================
    // Helper functions.
    // ========================================================================
    // Mask of prescaler bits that must all be one for a count tick.
    function automatic logic [7:0] ps_mask(input logic [3:0] ps);
        logic [8:0] m;
        m = (ps >= mtm_pkg::PS_MAX) ? 9'h100 : (9'h001 << ps);
        ps_mask = 8'(m - 9'h001);
    endfunction

    // ========================================================================
    // Pin synchronisers.
    // ========================================================================
    logic [1:0] sync1_q, sync1_d;   // First stage: fixed clock, pin clock.
    logic [1:0] sync2_q, sync2_d;   // Second stage, safe to use.
    logic [1:0] prev_q,  prev_d;    // Delayed copy for edge detection.
    logic       fix_rise;           // Fixed clock rising edge.
    logic       ext_rise;           // Pin clock rising edge.
    logic       ext_fall;           // Pin clock falling edge.

    // Only the second stage reads the first, so metastability cannot spread.
    always_comb begin
        sync1_d  = {ext_count_clock_in, fixed_freq_clock};
        sync2_d  = sync1_q;                                    // [RULE_11]
        prev_d   = sync2_q;
        fix_rise = sync2_q[0] & ~prev_q[0];
        ext_rise = sync2_q[1] & ~prev_q[1];
        ext_fall = ~sync2_q[1] & prev_q[1];
    end

    // Registers of the synchronisers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            prev_q  <= 2'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    // ========================================================================
    // Bus slave and timer state.
    // ========================================================================
    mtm_pkg::mtm_cfg_t     cfg_q, cfg_d;     // Software configuration.
    mtm_pkg::mtm_bus_req_t req_q, req_d;     // Address phase held for data phase.
    logic [7:0]            cnt_q, cnt_d;     // The count.
    logic [7:0]            pre_q, pre_d;     // Prescaler.
    logic                  flag_q, flag_d;   // Overflow flag.
    logic                  armed_q, armed_d; // Flag was read while set.
    logic [31:0]           rdata_q, rdata_d; // Read data for the data phase.
    logic                  irq_q, irq_d;     // Registered interrupt.
    logic                  running;          // Counter may advance.
    logic                  src_tick;         // Selected source edge.
    logic                  cnt_tick;         // Prescaled count enable.
    logic [7:0]            limit;            // Effective wrap value.
    logic                  flag_set;         // Overflow event this cycle.
    logic                  addr_ok;          // Valid address phase.
    logic                  wr_status;        // Data-phase write to status.
    logic                  wr_clock;         // Data-phase write to clock config.
    logic                  wr_wrap;          // Data-phase write to wrap limit.
    logic                  clr_strobe;       // Counter clear strobe written.
    logic                  clr_flag;         // Any clear of the flag.

    // Next-state logic for the bus, the prescaler, the count and the flag.
    always_comb begin
        // Wait mode is not an input: it leaves counting untouched.  [RULE_06]
        // Stop and debug both freeze the count and prescaler but keep state.    [RULE_07] [RULE_09]
        running = ~cfg_q.halt & ~stop_mode & ~debug_active;        // [RULE_10] [RULE_18]
        case (cfg_q.src)                                           // [RULE_03]
            mtm_pkg::MTM_SRC_BUS:      src_tick = 1'b1;            // [RULE_19]
            mtm_pkg::MTM_SRC_FIXED:    src_tick = fix_rise;
            mtm_pkg::MTM_SRC_EXT_FALL: src_tick = ext_fall;        // [RULE_04]
            mtm_pkg::MTM_SRC_EXT_RISE: src_tick = ext_rise;
            default:                   src_tick = 1'b1;
        endcase

        // Tick when every selected prescaler bit is one.           [RULE_05] [RULE_20]
        cnt_tick = running & src_tick &
                   ((pre_q & ps_mask(cfg_q.ps)) == ps_mask(cfg_q.ps));
        // A zero limit means free-running through the full range. [RULE_01]
        limit    = (cfg_q.wrap == mtm_pkg::RST_WRAP) ? mtm_pkg::FREE_LIMIT : cfg_q.wrap;
        flag_set = cnt_tick & (cnt_q == limit);

        // Decode of the held data phase.
        wr_status  = req_q.valid & req_q.write & (req_q.addr == mtm_pkg::OFS_STATUS);
        wr_clock   = req_q.valid & req_q.write & (req_q.addr == mtm_pkg::OFS_CLOCK);
        wr_wrap    = req_q.valid & req_q.write & (req_q.addr == mtm_pkg::OFS_WRAP);
        clr_strobe = wr_status & hwdata[mtm_pkg::SC_CLEAR_BIT];
        clr_flag   = clr_strobe | wr_wrap |
                     (wr_status & armed_q & ~hwdata[mtm_pkg::SC_FLAG_BIT]);  // [RULE_17]

        // Configuration writes; the count register takes none.    [RULE_15]
        cfg_d = cfg_q;
        if (wr_status) begin                                       // [RULE_13]
            cfg_d.irq_en = hwdata[mtm_pkg::SC_IRQEN_BIT];
            cfg_d.halt   = hwdata[mtm_pkg::SC_HALT_BIT];
        end
        if (wr_clock) begin                                        // [RULE_14]
            cfg_d.src = mtm_pkg::mtm_src_t'(hwdata[mtm_pkg::CK_SRC_HI:mtm_pkg::CK_SRC_LO]);
            cfg_d.ps  = hwdata[mtm_pkg::CK_PS_HI:mtm_pkg::CK_PS_LO];
        end
        if (wr_wrap) begin                                         // [RULE_16]
            cfg_d.wrap = hwdata[7:0];
        end

        // Prescaler advances only while running; new clock settings keep it.
        pre_d = running & src_tick ? 8'(pre_q + 8'h01) : pre_q;

        // Count: a clear or a limit write restarts it; a source or
        // prescale change does not touch it.                       [RULE_19]
        if (clr_strobe | wr_wrap) begin                            // [RULE_18]
            cnt_d = mtm_pkg::RST_COUNT;
            pre_d = mtm_pkg::RST_COUNT;
        end else if (flag_set) begin
            cnt_d = mtm_pkg::RST_COUNT;                            // [RULE_01]
        end else if (cnt_tick) begin
            cnt_d = 8'(cnt_q + 8'h01);
        end else begin
            cnt_d = cnt_q;
        end

        // A wrap in the same cycle as a clear keeps the flag set.
        if (flag_set) begin                                        // [RULE_17]
            flag_d = 1'b1;
        end else if (clr_flag) begin
            flag_d = 1'b0;
        end else begin
            flag_d = flag_q;
        end

        // Address phase is taken when hsel, hready and htrans[1] are all high.
        addr_ok       = hsel & hready & htrans[1];
        req_d.valid   = addr_ok;
        req_d.write   = hwrite;
        req_d.addr    = haddr[3:0];

        // Read data is built from next values so a read right after a
        // write sees the written value.
        rdata_d = 32'h0000_0000;
        if (addr_ok & ~hwrite) begin
            case (haddr[3:0])
                mtm_pkg::OFS_STATUS: begin                         // [RULE_13]
                    rdata_d[mtm_pkg::SC_FLAG_BIT]  = flag_d;
                    rdata_d[mtm_pkg::SC_IRQEN_BIT] = cfg_d.irq_en;
                    rdata_d[mtm_pkg::SC_HALT_BIT]  = cfg_d.halt;
                end
                mtm_pkg::OFS_CLOCK: begin                          // [RULE_14]
                    rdata_d[mtm_pkg::CK_SRC_HI:mtm_pkg::CK_SRC_LO] = cfg_d.src;
                    rdata_d[mtm_pkg::CK_PS_HI:mtm_pkg::CK_PS_LO]   = cfg_d.ps;
                end
                mtm_pkg::OFS_COUNT: rdata_d[7:0] = cnt_d;          // [RULE_15]
                mtm_pkg::OFS_WRAP:  rdata_d[7:0] = cfg_d.wrap;     // [RULE_16]
                default:            rdata_d = 32'h0000_0000;
            endcase
        end

        // Arm the read-then-write-zero clear; a status write consumes it.
        if (addr_ok & ~hwrite & (haddr[3:0] == mtm_pkg::OFS_STATUS) & flag_d) begin
            armed_d = 1'b1;
        end else if (wr_status | ~flag_d) begin
            armed_d = 1'b0;
        end else begin
            armed_d = armed_q;
        end

        irq_d = flag_d & cfg_d.irq_en;                             // [RULE_02]
        // Leaving the deep stop modes or a stop reset restores defaults.
        if (stop_exit_reset) begin                                 // [RULE_08]
            cfg_d   = '{irq_en: mtm_pkg::RST_IRQEN, halt: mtm_pkg::RST_HALT,
                        src: mtm_pkg::MTM_SRC_BUS, ps: mtm_pkg::RST_PS,
                        wrap: mtm_pkg::RST_WRAP};
            cnt_d   = mtm_pkg::RST_COUNT;
            pre_d   = mtm_pkg::RST_COUNT;
            flag_d  = 1'b0;
            armed_d = 1'b0;
            irq_d   = 1'b0;
        end
    end

    // Registers of the bus slave and the timer; no wait states, always OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q   <= '{irq_en: mtm_pkg::RST_IRQEN, halt: mtm_pkg::RST_HALT,
                         src: mtm_pkg::MTM_SRC_BUS, ps: mtm_pkg::RST_PS,
                         wrap: mtm_pkg::RST_WRAP};                 // [RULE_18]
            req_q   <= '0;
            cnt_q   <= mtm_pkg::RST_COUNT;
            pre_q   <= mtm_pkg::RST_COUNT;
            flag_q  <= 1'b0;
            armed_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            irq_q   <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            cfg_q   <= cfg_d;
            req_q   <= req_d;
            cnt_q   <= cnt_d;
            pre_q   <= pre_d;
            flag_q  <= flag_d;
            armed_q <= armed_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata       = rdata_q;
    assign overflow_irq = irq_q;

    // ========================================================================
    // Assertions.
    // ========================================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_read_flag;
        addr_ok && !hwrite && haddr[3:0] == mtm_pkg::OFS_STATUS && flag_d;
    endsequence
    sequence s_write_zero;
        wr_status && !hwdata[mtm_pkg::SC_FLAG_BIT] && !flag_set && !stop_exit_reset;
    endsequence

    property p_count_wraps;
        cnt_tick && cnt_q == limit && !stop_exit_reset |=> cnt_q == mtm_pkg::RST_COUNT;
    endproperty
    a_count_wraps: assert property (p_count_wraps) else $error("count did not wrap"); // [RULE_01]

    property p_irq_follows;
        flag_q && cfg_q.irq_en && !wr_status && !clr_flag && !stop_exit_reset |=> overflow_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq missing"); // [RULE_02]

    property p_ext_rise;
        running && cfg_q.src == mtm_pkg::MTM_SRC_EXT_RISE && cfg_q.ps == mtm_pkg::RST_PS
            && ext_rise |-> cnt_tick;
    endproperty
    a_ext_rise: assert property (p_ext_rise) else $error("pin edge not counted"); // [RULE_04]

    property p_ps_div;
        cnt_tick |-> (pre_q & ps_mask(cfg_q.ps)) == ps_mask(cfg_q.ps);
    endproperty
    a_ps_div: assert property (p_ps_div) else $error("prescale tick early"); // [RULE_05]

    property p_stop_freeze;
        stop_mode && !wr_status && !wr_wrap && !stop_exit_reset |=> cnt_q == $past(cnt_q);
    endproperty
    a_stop_freeze: assert property (p_stop_freeze) else $error("counted in stop"); // [RULE_07]

    property p_exit_reset;
        stop_exit_reset |=> cnt_q == mtm_pkg::RST_COUNT && cfg_q.halt && !flag_q;
    endproperty
    a_exit_reset: assert property (p_exit_reset) else $error("no reset on exit"); // [RULE_08]

    property p_debug_freeze;
        debug_active [*2] ##0 !wr_status && !wr_wrap && !stop_exit_reset
            |=> cnt_q == $past(cnt_q);
    endproperty
    a_debug_freeze: assert property (p_debug_freeze) else $error("counted in debug"); // [RULE_10]

    property p_sync_delay;
        ext_rise |-> $past(ext_count_clock_in, 2) && !$past(ext_count_clock_in, 3);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("pin edge too soon"); // [RULE_11]

    property p_status_zeros;
        addr_ok && !hwrite && haddr[3:0] == mtm_pkg::OFS_STATUS
            |=> hrdata[3:0] == 4'h0 && !hrdata[mtm_pkg::SC_CLEAR_BIT];
    endproperty
    a_status_zeros: assert property (p_status_zeros) else $error("status bits nonzero"); // [RULE_13]

    property p_read_write_clear;
        s_read_flag ##1 (!flag_set && !wr_status)[*2] ##1 s_write_zero |=> !flag_q;
    endproperty
    a_read_write_clear: assert property (p_read_write_clear) else $error("flag kept"); // [RULE_17]

    property p_clear_strobe;
        clr_strobe && !stop_exit_reset |=> cnt_q == mtm_pkg::RST_COUNT;
    endproperty
    a_clear_strobe: assert property (p_clear_strobe) else $error("strobe ignored"); // [RULE_18]

endmodule // mtm_timer

// >>> test/modulo_timer_8bit_bench.sv
/*
 * Self-checking bench for the modulo timer: register map, wrap and flag,
 * prescaler, clock sources, stop and debug freeze, stop-exit reset.
 * Assumes the single AHB-Lite slave answers with hreadyout on every cycle.
 */
`timescale 1ns/1ps

module modulo_timer_8bit_bench;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        fixed_freq_clock, ext_count_clock_in, overflow_irq;
    logic        stop_mode, stop_exit_reset, debug_active;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, pin_div_q;
    logic [2:0]  hsize;
    int          n_errors, comparisons;

    assign hready = hreadyout;  // The one slave drives the bus ready.

    mtm_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fixed_freq_clock(fixed_freq_clock), .ext_count_clock_in(ext_count_clock_in),
        .stop_mode(stop_mode), .stop_exit_reset(stop_exit_reset),
        .debug_active(debug_active), .overflow_irq(overflow_irq));

    // ========================================================================
    // Clock and pin clocks at one eighth of the bus rate, within the limit.
    // ========================================================================
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        pin_div_q <= pin_div_q + 2'h1;
        if (pin_div_q == 2'h3) begin
            fixed_freq_clock   <= ~fixed_freq_clock;
            ext_count_clock_in <= ~ext_count_clock_in;
        end
    end

    // ========================================================================
    // Shared tasks.
    // ========================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One single transfer; waits on ready in both phases, the watchdog bounds it.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        hsel <= 1'b1; htrans <= mtm_pkg::HTRANS_NONSEQ; haddr <= {28'h0, a}; hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;  // Sampled before this edge's updates land.
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(rd, {24'h0, e});
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (overflow_irq !== 1'b1 && n < 600) begin @(posedge hclk); n++; end
        check({31'h0, overflow_irq}, 32'h1);
    endtask
    // Clear with halt, set clock, run for a span, halt, then read the count.
    task automatic run_span(input logic [7:0] clk_cfg, input int cyc);
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h30);
        bus(1'b1, mtm_pkg::OFS_CLOCK, clk_cfg);
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h00);
        repeat (cyc) @(posedge hclk);
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h10);
        bus(1'b0, mtm_pkg::OFS_COUNT, 8'h00);
    endtask

    // ========================================================================
    // Scenarios.
    // ========================================================================
    task automatic t_reset_map();
        rchk(mtm_pkg::OFS_STATUS, 8'h10);
        rchk(mtm_pkg::OFS_CLOCK, 8'h00);
        bus(1'b1, mtm_pkg::OFS_CLOCK, 8'hFF);
        rchk(mtm_pkg::OFS_CLOCK, 8'h3F);
        bus(1'b1, mtm_pkg::OFS_COUNT, 8'h55);
        rchk(mtm_pkg::OFS_COUNT, 8'h00);
        bus(1'b1, mtm_pkg::OFS_WRAP, 8'hA5);
        rchk(mtm_pkg::OFS_WRAP, 8'hA5);
        rchk(4'h3, 8'h00);                      // Unmapped place reads zero.
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic t_wrap_flag();
        bus(1'b1, mtm_pkg::OFS_CLOCK, 8'h00);
        bus(1'b1, mtm_pkg::OFS_WRAP, 8'h02);
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h40);
        wait_irq();
        check({31'h0, overflow_irq}, 32'h1);
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h50);  // Write without a read: flag stays.
        bus(1'b0, mtm_pkg::OFS_COUNT, 8'h00);
        check({31'h0, rd <= 32'h2}, 32'h1);
        rchk(mtm_pkg::OFS_STATUS, 8'hD0);
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h50);
        rchk(mtm_pkg::OFS_STATUS, 8'h50);
        check({31'h0, overflow_irq}, 32'h0);
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h40);
        wait_irq();
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h50);  // Halt first, so no wrap meets the limit write.
        bus(1'b1, mtm_pkg::OFS_WRAP, 8'h05);
        rchk(mtm_pkg::OFS_STATUS, 8'h50);
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h40);
        wait_irq();
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h70);
        rchk(mtm_pkg::OFS_STATUS, 8'h50);
        rchk(mtm_pkg::OFS_COUNT, 8'h00);
    endtask
    task automatic t_prescale_sources();
        logic [31:0] e;
        bus(1'b1, mtm_pkg::OFS_WRAP, 8'h00);
        for (int p = 0; p < 10; p++) begin
            e = 200 >> ((p > 8) ? 8 : p);
            run_span({4'h0, p[3:0]}, 198);
            check({31'h0, rd + 2 >= e && rd <= e + 2}, 32'h1);
        end
        for (int s = 1; s < 4; s++) begin
            run_span({2'b00, s[1:0], 4'h0}, 198);
            check({31'h0, rd + 3 >= 25 && rd <= 28}, 32'h1);
            e = rd;
            bus(1'b1, mtm_pkg::OFS_CLOCK, 8'h05);
            rchk(mtm_pkg::OFS_COUNT, e[7:0]);
        end
    endtask
    task automatic t_freeze(input int which);
        logic [31:0] c1;
        run_span(8'h00, 10);
        bus(1'b1, mtm_pkg::OFS_STATUS, 8'h00);
        if (which == 0) stop_mode <= 1'b1;
        else debug_active <= 1'b1;
        @(posedge hclk);
        bus(1'b0, mtm_pkg::OFS_COUNT, 8'h00);
        c1 = rd;
        repeat (20) @(posedge hclk);
        rchk(mtm_pkg::OFS_COUNT, c1[7:0]);
        stop_mode <= 1'b0;
        debug_active <= 1'b0;
        repeat (20) @(posedge hclk);
        bus(1'b0, mtm_pkg::OFS_COUNT, 8'h00);
        check({31'h0, rd > c1 && rd < c1 + 30}, 32'h1);
    endtask
    task automatic t_exit_reset();
        bus(1'b1, mtm_pkg::OFS_CLOCK, 8'h15);
        bus(1'b1, mtm_pkg::OFS_WRAP, 8'h33);
        stop_exit_reset <= 1'b1;
        @(posedge hclk);
        stop_exit_reset <= 1'b0;
        rchk(mtm_pkg::OFS_STATUS, 8'h10);
        rchk(mtm_pkg::OFS_CLOCK, 8'h00);
        rchk(mtm_pkg::OFS_WRAP, 8'h00);
        rchk(mtm_pkg::OFS_COUNT, 8'h00);
    endtask

    // ========================================================================
    // Verdict, watchdog and main sequence.
    // ========================================================================
    task automatic tally_and_finish();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; fixed_freq_clock = 1'b0; ext_count_clock_in = 1'b0;
        stop_mode = 1'b0; stop_exit_reset = 1'b0; debug_active = 1'b0; pin_div_q = 2'h0;
        n_errors = 0; comparisons = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_map();
        t_wrap_flag();
        t_prescale_sources();
        t_freeze(0);
        t_freeze(1);
        t_exit_reset();
        tally_and_finish();
    end
endmodule // modulo_timer_8bit_bench
